/* hdl/exception_entry_sequencer.sv */
/*
  Exception entry sequencer: snapshot and change the status word, find the
  vector number, stack the frame on the right supervisor stack, fetch the
  new program counter and release execution.
  Assumes a simple bus master outside that serves one request at a time
  and pulses a done signal with read data; the core supplies its state.
  The core must reload its stack pointers from the outputs after RESUME.
*/
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps

// Summary of operation
// - entry runs four ordered steps: status, vector, stack, vector fetch.
// - the status word is copied before any state bit changes.
// - supervisor bit is set after the copy.
// - both trace control bits are cleared on entry.
// - reset and interrupts also load the interrupt priority mask.
// - interrupt vector comes from an interrupt acknowledge read.
// - coprocessor exceptions use the vector from its response.
// - internal exceptions take the internally generated vector; reset takes the fixed reset vector number.
// - frame size depends on type and execution point, on supervisor stack.
// - interrupt with master bit set clears it and copies short frame.
// - reset clears master bit only, no frame, then reads reset vector.
// - master bit set selects master stack for task exceptions.
// - interrupts clear master bit and use interrupt stack pointer.
// - vector offset is vector number shifted left by two.
// - vector address is vector base plus the offset.
// - load new program counter from vector, then resume execution.
module exception_entry_sequencer (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic EXC_REQ,
  input wire logic [1:0] EXC_KIND,
  input wire logic [7:0] INT_VECTOR,
  input wire logic [7:0] COPROC_VECTOR,
  input wire logic [4:0] FRAME_WORDS,
  input wire logic [15:0] FRAME_WORD [0:15],
  input wire logic [15:0] STATUS_IN,
  input wire logic [31:0] MASTER_STACK_POINTER_IN,
  input wire logic [31:0] INTERRUPT_STACK_POINTER_IN,
  input wire logic [31:0] VECTOR_BASE_REG,
  input wire logic [2:0] IRQ_LEVEL_INPUTS,
  output logic BUS_REQ,
  output logic BUS_WRITE,
  output logic BUS_IACK,
  output logic [31:0] BUS_ADDR,
  output logic [15:0] BUS_WDATA,
  input wire logic BUS_DONE,
  input wire logic [31:0] BUS_RDATA,
  output logic BUSY,
  output logic [15:0] STATUS_SAVED,
  output logic [15:0] STATUS_OUT,
  output logic [31:0] MASTER_STACK_POINTER_OUT,
  output logic [31:0] INTERRUPT_STACK_POINTER_OUT,
  output logic [7:0] VECTOR_NUMBER,
  output logic [31:0] NEW_PC,
  output logic RESUME
);
  // one-hot step codes; the copy step only runs for an interrupt that
  // arrives while the master stack is in use
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_STATUS = 7'h02,
    ST_VECTOR = 7'h04,
    ST_STACK = 7'h08,
    ST_COPY = 7'h10,
    ST_FETCH = 7'h20,
    ST_RESUME = 7'h40
  } state_e;

  // all that the sequencer keeps between steps; the status copy and the
  // working status word are separate so the copy never sees a change
  typedef struct packed {
    state_e st;
    logic [1:0] kind;
    logic [2:0] level;
    logic [15:0] saved;
    logic [15:0] status;
    logic [31:0] master_stack_pointer;
    logic [31:0] interrupt_stack_pointer;
    logic [7:0] vec;
    logic [31:0] pc;
    logic [1:0] stk;
    logic fw_start;
    logic resume;
  } seq_s;

  seq_s q, d;

  // frame writer handshake and the values that feed it
  logic fw_done;
  logic fw_wr_req;
  logic [31:0] fw_sp;
  logic [31:0] fw_addr;
  logic [15:0] fw_data;
  logic [31:0] fw_sp_in;
  logic [4:0] fw_words;
  logic [31:0] vec_addr;

  ////////////////////////////////////////////////////////////////////////////
  // vector address: base plus number times four; the sum wraps at 32 bits,
  // so a base near the top of memory folds the table back to address zero
  assign vec_addr = VECTOR_BASE_REG + (32'(q.vec) << exc_pkg::VEC_SHIFT);

  // the frame writer pushes on whichever stack the stacking step chose
  assign fw_sp_in = (q.stk == exc_pkg::STK_MASTER) ? q.master_stack_pointer : q.interrupt_stack_pointer;
  // the copy pass repeats only the short frame on the interrupt stack
  assign fw_words = (q.st == ST_COPY) ? exc_pkg::SHORT_FRAME_WORDS : FRAME_WORDS;

  // one writer serves both the frame and the copy pass; its busy flag is
  // not needed here, the done pulse alone ends each pass
  frame_writer u_frame_writer (
    .clk(CLK),
    .reset_n(RESET_N),
    .start(q.fw_start),
    .sp_in(fw_sp_in),
    .words(fw_words),
    .frame_word(FRAME_WORD),
    .busy(),
    .sp_out(fw_sp),
    .wr_req(fw_wr_req),
    .wr_addr(fw_addr),
    .wr_data(fw_data),
    .wr_done(BUS_DONE && fw_wr_req),
    .done(fw_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: one step at a time, each waits for its bus work to finish
  always_comb begin
    d = q;
    d.fw_start = 1'b0;
    d.resume = 1'b0;
    case (q.st)
      ST_IDLE: begin
        // a request is only looked at here; one raised during an entry is
        // dropped without notice, so the core holds it until BUSY falls
        if (EXC_REQ) begin
          d.kind = EXC_KIND;
          d.level = IRQ_LEVEL_INPUTS;
          d.saved = STATUS_IN; // copy taken before any change
          d.status = STATUS_IN;
          // both pointers are copied now; only a stack that takes a frame or a copy moves later
          d.master_stack_pointer = MASTER_STACK_POINTER_IN;
          d.interrupt_stack_pointer = INTERRUPT_STACK_POINTER_IN;
          d.st = ST_STATUS;
        end
      end
      ST_STATUS: begin
        // step one: supervisor on and tracing off for every kind
        d.status[exc_pkg::SR_SUPER] = 1'b1;
        d.status[exc_pkg::SR_TRACE_HI] = 1'b0;
        d.status[exc_pkg::SR_TRACE_LO] = 1'b0;
        // only reset and interrupts move the mask; the rest keep theirs
        if (q.kind == exc_pkg::KIND_RESET) begin
          d.status[exc_pkg::SR_MASK_LO +: exc_pkg::SR_MASK_W] = 3'h7;
        end else if (q.kind == exc_pkg::KIND_IRQ) begin
          d.status[exc_pkg::SR_MASK_LO +: exc_pkg::SR_MASK_W] = q.level;
        end
        d.st = ST_VECTOR;
      end
      ST_VECTOR: begin
        // step two: the vector source follows the kind taken at entry
        case (q.kind)
          exc_pkg::KIND_IRQ: begin
            // acknowledge read; the interrupter places the number
            // the number sits in the low byte; upper bits are ignored
            if (BUS_DONE) begin
              d.vec = BUS_RDATA[7:0];
              d.st = ST_STACK;
            end
          end
          exc_pkg::KIND_COPROC: begin
            // the response is taken as it stands in this cycle
            d.vec = COPROC_VECTOR;
            d.st = ST_STACK;
          end
          exc_pkg::KIND_RESET: begin
            d.vec = exc_pkg::VEC_RESET;
            d.st = ST_STACK;
          end
          default: begin
            d.vec = INT_VECTOR;
            d.st = ST_STACK;
          end
        endcase
      end
      ST_STACK: begin
        // step three: the first cycle picks a stack and starts the writer,
        // later cycles wait for its done pulse
        if (q.stk == exc_pkg::STK_NONE) begin
          // reset builds no frame and goes straight to the vector fetch
          if (q.kind == exc_pkg::KIND_RESET) begin
            d.status[exc_pkg::SR_MASTER] = 1'b0; // no frame for reset
            d.st = ST_FETCH;
          end else begin
            // master bit picks the master stack for task exceptions
            if (q.status[exc_pkg::SR_MASTER]) begin
              d.stk = exc_pkg::STK_MASTER;
            end else begin
              d.stk = exc_pkg::STK_IRQ;
            end
            d.fw_start = 1'b1;
          end
        end else if (fw_done) begin
          // the writer hands back the stack pointer after its last push
          if (q.stk == exc_pkg::STK_MASTER) begin
            d.master_stack_pointer = fw_sp;
          end else begin
            d.interrupt_stack_pointer = fw_sp;
          end
          // an interrupt that was stacked on the master stack needs a copy
          if (q.kind == exc_pkg::KIND_IRQ && q.stk == exc_pkg::STK_MASTER) begin
            // interrupt leaves the master stack, short frame copied
            d.status[exc_pkg::SR_MASTER] = 1'b0;
            d.stk = exc_pkg::STK_IRQ;
            d.fw_start = 1'b1;
            d.st = ST_COPY;
          end else begin
            d.stk = exc_pkg::STK_NONE;
            d.st = ST_FETCH;
          end
        end
      end
      ST_COPY: begin
        // the short frame again, this time on the interrupt stack
        if (fw_done) begin
          d.interrupt_stack_pointer = fw_sp;
          d.stk = exc_pkg::STK_NONE;
          d.st = ST_FETCH;
        end
      end
      ST_FETCH: begin
        // step four: read the new program counter at base plus offset
        // handler fetch waits for the vector read
        if (BUS_DONE) begin
          d.pc = BUS_RDATA;
          d.st = ST_RESUME;
        end
      end
      ST_RESUME: begin
        // one-cycle release; the core starts the handler at NEW_PC
        d.resume = 1'b1;
        d.st = ST_IDLE;
      end
      default: begin
        // an illegal code falls back to idle rather than hanging the core
        d.st = ST_IDLE;
      end
    endcase
  end

  // state register; reset leaves the sequencer idle with the reset status,
  // supervisor set and the mask at its highest level
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.status <= exc_pkg::SR_RESET;
      q.saved <= exc_pkg::SR_RESET;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus request mux: only one source active per step
  // the steps never overlap, so the priority order below is only a guard
  always_comb begin
    BUS_REQ = 1'b0;
    BUS_WRITE = 1'b0;
    BUS_IACK = 1'b0;
    BUS_ADDR = 32'h00000000;
    BUS_WDATA = 16'h0000;
    // acknowledge read, with the level in the low address bits
    if (q.st == ST_VECTOR && q.kind == exc_pkg::KIND_IRQ) begin
      BUS_REQ = 1'b1;
      BUS_IACK = 1'b1;
      BUS_ADDR = {29'h00000000, q.level};
    end else if (fw_wr_req) begin
      // frame and copy pushes, one word per done pulse
      BUS_REQ = 1'b1;
      BUS_WRITE = 1'b1;
      BUS_ADDR = fw_addr;
      BUS_WDATA = fw_data;
    end else if (q.st == ST_FETCH) begin
      // the vector read comes last, after every push has finished
      BUS_REQ = 1'b1;
      BUS_ADDR = vec_addr;
    end
  end

  // status, pointers, vector and program counter stand until the next entry
  assign BUSY = (q.st != ST_IDLE);
  assign STATUS_SAVED = q.saved;
  assign STATUS_OUT = q.status;
  assign MASTER_STACK_POINTER_OUT = q.master_stack_pointer;
  assign INTERRUPT_STACK_POINTER_OUT = q.interrupt_stack_pointer;
  assign VECTOR_NUMBER = q.vec;
  assign NEW_PC = q.pc;
  assign RESUME = q.resume;
endmodule : exception_entry_sequencer

/* hdl/exc_pkg.sv */
/*
  Shared constants and types for the exception entry sequencer: status word
  field positions, vector source codes, the short frame length and stack kinds.
  Assumes a 16-bit status word and 32-bit addresses and data.
*/
package exc_pkg;
  // status word field positions
  localparam int unsigned SR_TRACE_HI = 15;
  localparam int unsigned SR_TRACE_LO = 14;
  localparam int unsigned SR_SUPER = 13;
  localparam int unsigned SR_MASTER = 12;
  localparam int unsigned SR_MASK_LO = 8;
  localparam int unsigned SR_MASK_W = 3;
  localparam logic [15:0] SR_RESET = 16'h2700;
  // exception kinds
  localparam logic [1:0] KIND_INTERNAL = 2'h0;
  localparam logic [1:0] KIND_IRQ = 2'h1;
  localparam logic [1:0] KIND_COPROC = 2'h2;
  localparam logic [1:0] KIND_RESET = 2'h3;
  // reset vector number
  localparam logic [7:0] VEC_RESET = 8'h00;
  // short frame length in 16-bit words
  localparam logic [4:0] SHORT_FRAME_WORDS = 5'h04;
  // vector offset shift: number times four
  localparam int unsigned VEC_SHIFT = 2;
  // stack pointer select codes
  localparam logic [1:0] STK_NONE = 2'h0;
  localparam logic [1:0] STK_MASTER = 2'h1;
  localparam logic [1:0] STK_IRQ = 2'h2;
endpackage : exc_pkg

/* hdl/frame_writer.sv */
/*
  Frame writer: pushes a frame of 16-bit words onto a stack, one word per
  accepted bus write, predecrementing the given stack pointer.
  Assumes the bus side answers each write with a one-cycle done pulse.
*/
`timescale 1ns/1ps
module frame_writer (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [31:0] sp_in,
  input wire logic [4:0] words,
  input wire logic [15:0] frame_word [0:15],
  output logic busy,
  output logic [31:0] sp_out,
  output logic wr_req,
  output logic [31:0] wr_addr,
  output logic [15:0] wr_data,
  input wire logic wr_done,
  output logic done
);
  typedef struct packed {
    logic busy;
    logic [31:0] sp;
    logic [4:0] left;
    logic done;
  } fw_s;

  fw_s q, d;

  ////////////////////////////////////////////////////////////////////////////
  // next state: word index counts down so the first word lands lowest
  always_comb begin
    d = q;
    d.done = 1'b0;
    if (start && !q.busy) begin
      d.busy = 1'b1;
      d.sp = sp_in;
      d.left = words;
    end else if (q.busy && wr_done) begin
      d.sp = q.sp - 32'h00000002;
      d.left = q.left - 5'h01;
      if (q.left == 5'h01) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign busy = q.busy;
  assign sp_out = q.sp;
  assign done = q.done;
  assign wr_req = q.busy;
  assign wr_addr = q.sp - 32'h00000002; // predecrement address
  assign wr_data = frame_word[q.left[3:0] - 4'h1];
endmodule : frame_writer

/* testbench/exception_entry_monitor.sv */
/* Checker for the exception entry sequencer, watching its top ports.
   Assumes one clock and an active-low asynchronous reset. */
`timescale 1ns/1ps
module exception_entry_monitor (
  input logic CLK,
  input logic RESET_N,
  input logic EXC_REQ,
  input logic [1:0] EXC_KIND,
  input logic [15:0] STATUS_IN,
  input logic [2:0] IRQ_LEVEL_INPUTS,
  input logic [31:0] VECTOR_BASE_REG,
  input logic BUS_REQ,
  input logic BUS_WRITE,
  input logic BUS_IACK,
  input logic [31:0] BUS_ADDR,
  input logic BUS_DONE,
  input logic [31:0] BUS_RDATA,
  input logic BUSY,
  input logic [15:0] STATUS_SAVED,
  input logic [15:0] STATUS_OUT,
  input logic [7:0] VECTOR_NUMBER,
  input logic [31:0] NEW_PC,
  input logic RESUME
);
  logic [1:0] kind_q;
  logic [15:0] sr_q;
  logic [2:0] lvl_q;
  logic [31:0] pc_q;
  logic fetch;
  logic [2:0] mask_exp;
  assign fetch = BUS_REQ && !BUS_WRITE && !BUS_IACK;
  assign mask_exp = kind_q == exc_pkg::KIND_RESET ? 3'h7 :
                    kind_q == exc_pkg::KIND_IRQ ? lvl_q : sr_q[10:8];
  // keep what was taken so the outcome can be judged at resume
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      kind_q <= 2'h0;
      sr_q <= 16'h0000;
      lvl_q <= 3'h0;
      pc_q <= 32'h00000000;
    end else begin
      if (EXC_REQ && !BUSY) begin
        kind_q <= EXC_KIND;
        sr_q <= STATUS_IN;
        lvl_q <= IRQ_LEVEL_INPUTS;
      end
      if (fetch && BUS_DONE) begin
        pc_q <= BUS_RDATA;
      end
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  ////////////////////////////////////////
  a_saved_copy: assert property (RESUME |-> STATUS_SAVED == sr_q)
    else $error("saved status differs");
  a_super_notrace: assert property (RESUME |-> STATUS_OUT[15:13] == 3'h1)
    else $error("state bits wrong");
  a_mask_update: assert property (RESUME |-> STATUS_OUT[10:8] == mask_exp)
    else $error("priority mask wrong");
  // kind bit 0 marks interrupt and reset, the two that leave the master stack
  a_master_bit: assert property (RESUME |->
    STATUS_OUT[12] == (sr_q[12] && !kind_q[0]))
    else $error("master bit wrong");
  a_iack_vector: assert property (BUS_IACK && BUS_DONE |=>
    VECTOR_NUMBER == 8'($past(BUS_RDATA)))
    else $error("vector not from acknowledge");
  a_iack_level: assert property (BUS_IACK |-> BUS_ADDR[2:0] == lvl_q)
    else $error("acknowledge level wrong");
  a_reset_nowrite: assert property (BUSY && kind_q == exc_pkg::KIND_RESET |->
    !BUS_WRITE)
    else $error("reset wrote a frame");
  a_fetch_addr: assert property (fetch |->
    BUS_ADDR == VECTOR_BASE_REG + {VECTOR_NUMBER, 2'h0})
    else $error("vector address wrong");
  a_pc_resume: assert property (fetch && BUS_DONE |->
    ##[1:2] (RESUME && NEW_PC == pc_q))
    else $error("resume or pc wrong");
  a_entry_bound: assert property ($rose(BUSY) |-> ##[4:400] RESUME)
    else $error("entry did not finish");
endmodule : exception_entry_monitor

bind exception_entry_sequencer exception_entry_monitor mon_u (.CLK, .RESET_N, .EXC_REQ,
  .EXC_KIND, .STATUS_IN, .IRQ_LEVEL_INPUTS, .VECTOR_BASE_REG, .BUS_REQ, .BUS_WRITE,
  .BUS_IACK, .BUS_ADDR, .BUS_DONE, .BUS_RDATA, .BUSY, .STATUS_SAVED, .STATUS_OUT,
  .VECTOR_NUMBER, .NEW_PC, .RESUME);

/* testbench/bus_partner.sv */
/* Bus partner: answers each request after a chosen wait, logs writes.
   Assumes requests are held until done and come one at a time. */
`timescale 1ns/1ps
module bus_partner (
  input logic clk,
  input logic reset_n,
  input logic [1:0] slow,
  input logic [7:0] iack_vec,
  input logic req,
  input logic wr,
  input logic iack,
  input logic [31:0] addr,
  input logic [15:0] wdata,
  output logic done,
  output logic [31:0] rdata,
  output int writes,
  output logic [31:0] last_addr,
  output logic [15:0] last_data
);
  logic [1:0] cnt;
  logic tick;
  logic [31:0] ans;
  // outside the answer cycle the lines toggle, so stale data never looks valid
  assign rdata = done ? ans : {16{tick, ~tick}};
  // wait slow cycles, then pulse done for one cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      done <= 1'b0;
      cnt <= 2'h0;
      tick <= 1'b0;
      ans <= 32'h00000000;
      writes <= 0;
      last_addr <= 32'h00000000;
      last_data <= 16'h0000;
    end else begin
      tick <= ~tick;
      done <= 1'b0;
      if (done) begin
        cnt <= 2'h0;
      end else if (req && cnt != slow) begin
        cnt <= cnt + 2'h1;
      end else if (req) begin
        done <= 1'b1;
        ans <= iack ? {24'hC3C3C3, iack_vec} : addr ^ 32'hA5A50000;
        if (wr) begin
          writes <= writes + 1;
          last_addr <= addr;
          last_data <= wdata;
        end
      end
    end
  end
endmodule : bus_partner

/* testbench/tb_exception_entry_sequencer.sv */
/* Testbench for the exception entry sequencer: runs each entry kind.
   Assumes the bus partner model and the bound checker. */
`timescale 1ns/1ps
module tb_exception_entry_sequencer;
  logic CLK, RESET_N, EXC_REQ, BUS_REQ, BUS_WRITE, BUS_IACK, BUS_DONE, BUSY, RESUME;
  logic [1:0] EXC_KIND, slow;
  logic [7:0] INT_VECTOR, COPROC_VECTOR, VECTOR_NUMBER;
  logic [4:0] FRAME_WORDS;
  logic [15:0] FRAME_WORD [0:15];
  logic [15:0] STATUS_IN, STATUS_SAVED, STATUS_OUT, BUS_WDATA, last_data;
  logic [31:0] MASTER_STACK_POINTER_IN, INTERRUPT_STACK_POINTER_IN, VECTOR_BASE_REG;
  logic [31:0] BUS_ADDR, BUS_RDATA, NEW_PC, last_addr;
  logic [31:0] MASTER_STACK_POINTER_OUT, INTERRUPT_STACK_POINTER_OUT;
  logic [2:0] IRQ_LEVEL_INPUTS;
  int writes, fail_count, comparisons;
  exception_entry_sequencer dut_u (.CLK, .RESET_N, .EXC_REQ, .EXC_KIND, .INT_VECTOR,
    .COPROC_VECTOR, .FRAME_WORDS, .FRAME_WORD, .STATUS_IN, .MASTER_STACK_POINTER_IN,
    .INTERRUPT_STACK_POINTER_IN, .VECTOR_BASE_REG, .IRQ_LEVEL_INPUTS, .BUS_REQ, .BUS_WRITE,
    .BUS_IACK, .BUS_ADDR, .BUS_WDATA, .BUS_DONE, .BUS_RDATA, .BUSY, .STATUS_SAVED,
    .STATUS_OUT, .MASTER_STACK_POINTER_OUT, .INTERRUPT_STACK_POINTER_OUT, .VECTOR_NUMBER,
    .NEW_PC, .RESUME);
  bus_partner far_u (.clk(CLK), .reset_n(RESET_N), .slow, .iack_vec(8'h40), .req(BUS_REQ),
    .wr(BUS_WRITE), .iack(BUS_IACK), .addr(BUS_ADDR), .wdata(BUS_WDATA), .done(BUS_DONE),
    .rdata(BUS_RDATA), .writes, .last_addr, .last_data);
  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  // one entry: request, wait for resume under a bound, then judge the result
  task automatic run(input logic [1:0] kind, input logic [15:0] sr, input logic [2:0] lvl,
      input logic [4:0] words, input logic [1:0] sl, input logic [7:0] vec,
      input logic [15:0] exp_sr, input int exp_wr, input logic [31:0] master_stack_pointer, interrupt_stack_pointer);
    int w0;
    int n;
    w0 = writes;
    @(posedge CLK);
    EXC_REQ <= 1'b1;
    EXC_KIND <= kind;
    STATUS_IN <= sr;
    IRQ_LEVEL_INPUTS <= lvl;
    FRAME_WORDS <= words;
    slow <= sl;
    @(posedge CLK);
    EXC_REQ <= 1'b0;
    n = 0;
    do begin
      @(posedge CLK);
      #1;
      n++;
    end while (RESUME !== 1'b1 && n < 400);
    check({31'h0, RESUME}, 32'h1);
    check(STATUS_SAVED, sr);
    check(STATUS_OUT, exp_sr);
    check(VECTOR_NUMBER, vec);
    check(NEW_PC, (VECTOR_BASE_REG + {vec, 2'h0}) ^ 32'hA5A50000);
    check(writes - w0, exp_wr);
    check(MASTER_STACK_POINTER_OUT, master_stack_pointer);
    check(INTERRUPT_STACK_POINTER_OUT, interrupt_stack_pointer);
    if (exp_wr > 0) begin
      check(last_addr, (sr[12] && kind != exc_pkg::KIND_IRQ) ? master_stack_pointer : interrupt_stack_pointer);
      check(last_data, FRAME_WORD[0]);
    end
  endtask : run
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  // watchdog: six entries need far fewer cycles than this
  initial begin
    repeat (8000) @(posedge CLK);
    fail_count++;
    wrap_up();
  end
  initial begin
    RESET_N = 1'b0;
    EXC_REQ = 1'b0;
    EXC_KIND = 2'h0;
    slow = 2'h0;
    INT_VECTOR = 8'h18;
    COPROC_VECTOR = 8'h37;
    FRAME_WORDS = 5'h04;
    STATUS_IN = 16'h0000;
    IRQ_LEVEL_INPUTS = 3'h0;
    MASTER_STACK_POINTER_IN = 32'h00008000;
    INTERRUPT_STACK_POINTER_IN = 32'h00004000;
    VECTOR_BASE_REG = 32'h00010000;
    for (int i = 0; i < 16; i++) FRAME_WORD[i] = 16'h1000 + 16'(i);
    repeat (8) @(posedge CLK);
    RESET_N <= 1'b1;
    run(exc_pkg::KIND_RESET, 16'hD000, 3'h0, 5'h04, 2'h0, exc_pkg::VEC_RESET, 16'h2700, 0,
      32'h00008000, 32'h00004000);
    run(exc_pkg::KIND_IRQ, 16'hC300, 3'h5, 5'h04, 2'h0, 8'h40, 16'h2500, 4,
      32'h00008000, 32'h00003FF8);
    run(exc_pkg::KIND_IRQ, 16'h5000, 3'h3, 5'h04, 2'h3, 8'h40, 16'h2300, 8,
      32'h00007FF8, 32'h00003FF8);
    run(exc_pkg::KIND_INTERNAL, 16'h9200, 3'h6, 5'h03, 2'h1, 8'h18, 16'h3200, 3,
      32'h00007FFA, 32'h00004000);
    run(exc_pkg::KIND_COPROC, 16'h4700, 3'h1, 5'h10, 2'h2, 8'h37, 16'h2700, 16,
      32'h00008000, 32'h00003FE0);
    run(exc_pkg::KIND_RESET, 16'h1000, 3'h2, 5'h04, 2'h1, exc_pkg::VEC_RESET, 16'h2700, 0,
      32'h00008000, 32'h00004000);
    wrap_up();
  end
endmodule : tb_exception_entry_sequencer
